// ---- dcif_defines.svh ----
// Register offsets, field positions and reset values of the channel flag block
`ifndef DCIF_DEFINES_SVH
`define DCIF_DEFINES_SVH
`define DCIF_OFF_FLAGS    8'h14
`define DCIF_OFF_ENABLES  8'h18
`define DCIF_OFF_CTRL     8'h1c
`define DCIF_OFF_STATE    8'h20
`define DCIF_BIT_DONE     2
`define DCIF_BIT_OVF      1
`define DCIF_BIT_BERR     0
`define DCIF_BIT_RUN      0
`define DCIF_NFLAGS       3
`define DCIF_FLAGS_RST    3'h0
`define DCIF_ADDR_RST     32'h00000000
`define DCIF_SYNC_RST     2'h0
`define DCIF_STATE_W      2
`endif

// ---- dcif_pkg.sv ----
// Types shared by the channel flag block
package dcif_pkg;
  typedef struct packed {
    logic done;
    logic ovf;
    logic berr;
  } dcif_evt_t;
  typedef enum logic [1:0] {
    DCIF_IDLE,
    DCIF_BUSY,
    DCIF_FIN
  } dcif_state_t;
endpackage

// ---- dcif_flag_bank.sv ----
// Sticky event flags with write-one-to-clear and mask
`timescale 1ns/1ps
`include "dcif_defines.svh"
module dcif_flag_bank
  import dcif_pkg::*;
(
  input  wire logic                     clk,
  input  wire logic                     arst_n,
  input  wire logic                     ce,
  input  wire dcif_evt_t                evt,
  input  wire logic                     clr_we,
  input  wire logic [`DCIF_NFLAGS-1:0]  clr_bits,
  input  wire logic                     en_we,
  input  wire logic [`DCIF_NFLAGS-1:0]  en_wdata,
  output logic      [`DCIF_NFLAGS-1:0]  flags,
  output logic      [`DCIF_NFLAGS-1:0]  enables,
  output logic                          irq
);
  logic [`DCIF_NFLAGS-1:0] set_v;
  assign set_v = evt;

  // Per-flag sticky bit; a set in the clear cycle wins
  genvar i;
  generate
    for (i = 0; i < `DCIF_NFLAGS; i++) begin : g_flag
      always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
          flags[i] <= 1'b0;
        end else if (ce) begin
          if (set_v[i]) begin
            flags[i] <= 1'b1;
          end else if (clr_we && clr_bits[i]) begin
            flags[i] <= 1'b0;
          end
        end
      end
    end
  endgenerate

  // Enable register
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      enables <= `DCIF_FLAGS_RST;
    end else if (ce && en_we) begin
      enables <= en_wdata;
    end
  end

  // Level interrupt
  assign irq = |(flags & enables);
endmodule

// ---- dcif_channel_flags.sv ----
// Channel interrupt flag block with APB registers and channel event detection
//
// Our own choice: the APB interface to the registers.
`timescale 1ns/1ps
`include "dcif_defines.svh"
module dcif_channel_flags
  import dcif_pkg::*;
(
  input  wire logic        clk,
  input  wire logic        arst_n,
  input  wire logic        ce,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic [31:0] cur_addr,
  input  wire logic [31:0] end_addr,
  input  wire logic        flow_req,
  input  wire logic        flow_term,
  input  wire logic        bus_err,
  output logic             run,
  output logic             req_accept,
  output logic             irq
);
  logic [1:0]              req_sync;
  logic [1:0]              term_sync;
  logic                    req_s;
  logic                    term_s;
  logic                    run_reg;
  dcif_state_t             state_reg;
  dcif_state_t             state_next;
  dcif_evt_t               evt;
  logic                    wr_acc;
  logic                    rd_acc;
  logic                    hit;
  logic                    at_end;
  logic [`DCIF_NFLAGS-1:0] flags;
  logic [`DCIF_NFLAGS-1:0] enables;
  logic [31:0]             rdata_next;
  logic                    flags_we;
  logic                    enables_we;
  logic                    ctrl_we;

  // Pin inputs from the peripheral pass two flops
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      req_sync  <= `DCIF_SYNC_RST;
      term_sync <= `DCIF_SYNC_RST;
    end else if (ce) begin
      req_sync  <= {req_sync[0], flow_req};
      term_sync <= {term_sync[0], flow_term};
    end
  end
  assign req_s  = req_sync[1];
  assign term_s = term_sync[1];

  // APB access decode
  assign wr_acc = psel && penable && pwrite && ce;
  assign rd_acc = psel && !penable && !pwrite && ce;
  assign hit    = (paddr == `DCIF_OFF_FLAGS) || (paddr == `DCIF_OFF_ENABLES) ||
                  (paddr == `DCIF_OFF_CTRL) || (paddr == `DCIF_OFF_STATE);
  assign pready  = 1'b1;
  assign pslverr = psel && penable && !hit;

  // Register write strobes
  assign flags_we   = wr_acc && (paddr == `DCIF_OFF_FLAGS);
  assign enables_we = wr_acc && (paddr == `DCIF_OFF_ENABLES);
  assign ctrl_we    = wr_acc && (paddr == `DCIF_OFF_CTRL);

  // Run control bit
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      run_reg <= 1'b0;
    end else if (ctrl_we) begin
      run_reg <= pwdata[`DCIF_BIT_RUN];
    end
  end
  assign run = run_reg;

  assign at_end = (cur_addr == end_addr);
  assign req_accept = run_reg && req_s && (state_reg == DCIF_BUSY) && !at_end;

  // Channel progress: idle, busy, finished
  always_comb begin
    state_next = state_reg;
    unique case (state_reg)
      DCIF_IDLE: begin
        if (run_reg && req_s) begin
          state_next = DCIF_BUSY;
        end
      end
      DCIF_BUSY: begin
        if (!run_reg) begin
          state_next = DCIF_IDLE;
        end else if (at_end || term_s) begin
          state_next = DCIF_FIN;
        end
      end
      DCIF_FIN: begin
        if (!run_reg) begin
          state_next = DCIF_IDLE;
        end
      end
      default: begin
        state_next = DCIF_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      state_reg <= DCIF_IDLE;
    end else if (ce) begin
      state_reg <= state_next;
    end
  end

  // Event pulses into the sticky flags
  always_comb begin
    evt.done = (state_reg == DCIF_BUSY) && at_end;
    evt.ovf  = (state_reg == DCIF_FIN) && run_reg && req_s;
    evt.berr = bus_err;
  end

  dcif_flag_bank u_bank (
    .clk      (clk),
    .arst_n   (arst_n),
    .ce       (ce),
    .evt      (evt),
    .clr_we   (flags_we),
    .clr_bits (pwdata[`DCIF_NFLAGS-1:0]),
    .en_we    (enables_we),
    .en_wdata (pwdata[`DCIF_NFLAGS-1:0]),
    .flags    (flags),
    .enables  (enables),
    .irq      (irq)
  );

  // Read mux
  always_comb begin
    rdata_next = `DCIF_ADDR_RST;
    unique case (paddr)
      `DCIF_OFF_FLAGS:   rdata_next[`DCIF_NFLAGS-1:0] = flags;
      `DCIF_OFF_ENABLES: rdata_next[`DCIF_NFLAGS-1:0] = enables;
      `DCIF_OFF_CTRL:    rdata_next[`DCIF_BIT_RUN] = run_reg;
      `DCIF_OFF_STATE:   rdata_next[`DCIF_STATE_W-1:0] = state_reg;
      default:           rdata_next = `DCIF_ADDR_RST;
    endcase
  end

  // Read data captured in setup cycle, held in access
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      prdata <= `DCIF_ADDR_RST;
    end else if (rd_acc) begin
      prdata <= rdata_next;
    end
  end

  // Assertions
  // Channel in flight meets its end address
  sequence s_busy_at_end;
    ce && run_reg && state_reg == DCIF_BUSY && at_end;
  endsequence

  // Channel in flight stopped by the peripheral short of the end
  sequence s_busy_term;
    ce && run_reg && state_reg == DCIF_BUSY && term_s && !at_end;
  endsequence

  // Peripheral still asking after the transfer is over
  sequence s_fin_req;
    ce && state_reg == DCIF_FIN && run_reg && req_s;
  endsequence

  // Request pin seen high, then one more enabled edge
  sequence s_req_pin_held;
    ce && flow_req ##1 ce;
  endsequence

  // Done flag up with the channel finished
  sequence s_done_fin;
    flags[`DCIF_BIT_DONE] && state_reg == DCIF_FIN;
  endsequence

  // Software write aimed at the bus error flag
  sequence s_berr_clear;
    flags_we && pwdata[`DCIF_BIT_BERR];
  endsequence

  // Completion flag follows end address
  AST_DONE_SET: assert property (@(posedge clk) disable iff (!arst_n)
    ce && state_reg == DCIF_BUSY && at_end |=> flags[`DCIF_BIT_DONE])
    else $error("done flag not set at end address");

  // Completion also finishes the channel
  AST_DONE_FIN: assert property (@(posedge clk) disable iff (!arst_n)
    s_busy_at_end |=> s_done_fin)
    else $error("end address did not finish with done flag");

  // Terminate leaves the completion flag alone
  AST_TERM_NO_DONE: assert property (@(posedge clk) disable iff (!arst_n)
    ce && state_reg == DCIF_BUSY && term_s && !at_end && !flags[`DCIF_BIT_DONE] |=> !flags[`DCIF_BIT_DONE])
    else $error("terminate set done flag");

  // Terminate finishes the channel without completion
  AST_TERM_FIN: assert property (@(posedge clk) disable iff (!arst_n)
    s_busy_term |=> state_reg == DCIF_FIN && !$rose(flags[`DCIF_BIT_DONE]))
    else $error("terminate did not finish cleanly");

  // Late request raises the overflow flag
  AST_OVF_SET: assert property (@(posedge clk) disable iff (!arst_n)
    s_fin_req |=> flags[`DCIF_BIT_OVF])
    else $error("overflow flag not set");

  // Overflow flag only from the finished state
  AST_OVF_ONLY_FIN: assert property (@(posedge clk) disable iff (!arst_n)
    state_reg != DCIF_FIN && !flags[`DCIF_BIT_OVF] |=> !flags[`DCIF_BIT_OVF])
    else $error("overflow flag set outside finished state");

  // Bus error pulse raises its flag
  AST_BERR_SET: assert property (@(posedge clk) disable iff (!arst_n)
    ce && bus_err |=> flags[`DCIF_BIT_BERR])
    else $error("bus error flag not set");

  // Flag holds until software clears it
  AST_FLAG_STICKY: assert property (@(posedge clk) disable iff (!arst_n)
    flags[`DCIF_BIT_BERR] && !flags_we |=> flags[`DCIF_BIT_BERR])
    else $error("bus error flag lost without clear");

  // Clear write drops the bus error flag
  AST_BERR_CLEAR: assert property (@(posedge clk) disable iff (!arst_n)
    s_berr_clear ##0 !bus_err |=> !flags[`DCIF_BIT_BERR])
    else $error("bus error flag not cleared");

  // A new error in the clear cycle wins
  AST_SET_WINS: assert property (@(posedge clk) disable iff (!arst_n)
    s_berr_clear ##0 bus_err |=> flags[`DCIF_BIT_BERR])
    else $error("clear beat a new bus error");

  // Enable write lands
  AST_EN_WRITE: assert property (@(posedge clk) disable iff (!arst_n)
    enables_we |=> enables == $past(pwdata[`DCIF_NFLAGS-1:0]))
    else $error("enable write not stored");

  // Enables change only by a write
  AST_EN_HOLD: assert property (@(posedge clk) disable iff (!arst_n)
    !enables_we |=> $stable(enables))
    else $error("enables changed without write");

  // Run clear keeps the channel idle
  AST_RUN_IGNORE: assert property (@(posedge clk) disable iff (!arst_n)
    !run_reg && state_reg == DCIF_IDLE && ce |=> state_reg == DCIF_IDLE)
    else $error("request serviced with run clear");

  // No request accepted with run clear
  AST_RUN_NO_ACCEPT: assert property (@(posedge clk) disable iff (!arst_n)
    !run_reg |-> !req_accept)
    else $error("request accepted with run clear");

  // Request pin reaches the logic after two flops
  AST_REQ_SYNC: assert property (@(posedge clk) disable iff (!arst_n)
    s_req_pin_held |=> req_s)
    else $error("request not seen after two flops");

  // Enabled bus error raises the interrupt
  AST_IRQ: assert property (@(posedge clk) disable iff (!arst_n)
    ce && bus_err && enables[`DCIF_BIT_BERR] && !enables_we |=> irq)
    else $error("irq missing for enabled bus error");

  // No interrupt with every source masked
  AST_IRQ_QUIET: assert property (@(posedge clk) disable iff (!arst_n)
    enables == `DCIF_FLAGS_RST |-> !irq)
    else $error("irq with all sources masked");

  // Clock enable low freezes the state
  AST_CE_FREEZE: assert property (@(posedge clk) disable iff (!arst_n)
    !ce |=> $stable(state_reg) && $stable(flags) && $stable(enables) && $stable(run_reg) && $stable(prdata))
    else $error("state moved with clock enable low");

  // Unmapped read returns zero
  AST_UNMAPPED_READ: assert property (@(posedge clk) disable iff (!arst_n)
    ce && psel && !penable && !pwrite && !hit |=> prdata == `DCIF_ADDR_RST)
    else $error("unmapped read not zero");

  // Mapped access never flags an error
  AST_PSLVERR_MAPPED: assert property (@(posedge clk) disable iff (!arst_n)
    psel && penable && hit |-> !pslverr)
    else $error("error response on mapped address");

  // Channel state stays on a legal code
  AST_STATE_LEGAL: assert property (@(posedge clk) disable iff (!arst_n)
    state_reg inside {DCIF_IDLE, DCIF_BUSY, DCIF_FIN})
    else $error("illegal channel state");
endmodule

// ---- dcif_periph.sv ----
// Peripheral model driving flow-control request and terminate levels
`timescale 1ns/1ps
module dcif_periph (
  input  wire logic clk,
  input  wire logic want,
  input  wire logic stop,
  output logic      flow_req,
  output logic      flow_term
);
  // Levels change only after a clock edge
  always_ff @(posedge clk) begin
    flow_req  <= want;
    flow_term <= stop;
  end
endmodule

// ---- dcif_channel_flags_tb.sv ----
// Self-checking bench of the channel flag block
`timescale 1ns/1ps
`include "dcif_defines.svh"
module dcif_channel_flags_tb;
  import dcif_pkg::*;
  logic        clk, arst_n, ce, psel, penable, pwrite, bus_err, want, stop;
  logic        pready, pslverr, run, req_accept, irq, flow_req, flow_term, serr;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata, cur_addr, end_addr, r;
  int          failures, cmp_count;
  dcif_periph pm (.clk(clk), .want(want), .stop(stop), .flow_req(flow_req), .flow_term(flow_term));
  dcif_channel_flags dut (.clk(clk), .arst_n(arst_n), .ce(ce), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .cur_addr(cur_addr), .end_addr(end_addr), .flow_req(flow_req),
    .flow_term(flow_term), .bus_err(bus_err), .run(run), .req_accept(req_accept), .irq(irq));
  // Clock of 40 ns
  initial begin
    clk = 0;
    forever #20 clk = ~clk;
  end
  // One APB transfer, held until pready is seen
  task xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    psel <= 1; penable <= 0; pwrite <= w; paddr <= a; pwdata <= d;
    @(posedge clk);
    penable <= 1;
    do @(posedge clk); while (pready !== 1'b1);
    r = prdata;
    serr = pslverr;
    psel <= 0; penable <= 0;
  endtask
  task chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      failures++;
      $display("BAD %0t got %h want %h", $time, got, exp);
    end
  endtask
  task rd(input logic [7:0] a, input logic [31:0] exp);
    xfer(0, a, 0);
    chk(r, exp);
  endtask
  task ticks(input int n);
    repeat (n) @(posedge clk);
  endtask
  task t_reset;
    rd(`DCIF_OFF_FLAGS, 0);
    rd(`DCIF_OFF_ENABLES, 0);
  endtask
  task t_berr;
    xfer(1, `DCIF_OFF_ENABLES, 7);
    rd(`DCIF_OFF_ENABLES, 7);
    bus_err <= 1;
    @(posedge clk);
    bus_err <= 0;
    ticks(2);
    rd(`DCIF_OFF_FLAGS, 1);
    chk({31'h0, irq}, 1);
    xfer(1, `DCIF_OFF_ENABLES, 6);
    ticks(1);
    chk({31'h0, irq}, 0);
    xfer(1, `DCIF_OFF_FLAGS, 6);
    rd(`DCIF_OFF_FLAGS, 1);
    xfer(1, `DCIF_OFF_FLAGS, 1);
    rd(`DCIF_OFF_FLAGS, 0);
  endtask
  task t_done_ovf;
    xfer(1, `DCIF_OFF_CTRL, 1);
    want <= 1;
    ticks(5);
    @(negedge clk);
    chk({31'h0, run}, 1);
    chk({31'h0, req_accept}, 1);
    rd(`DCIF_OFF_STATE, 1);
    want <= 0;
    // Request must be gone through the sync flops before the end
    ticks(4);
    cur_addr <= end_addr;
    ticks(5);
    rd(`DCIF_OFF_FLAGS, 4);
    chk({31'h0, irq}, 1);
    want <= 1;
    ticks(5);
    rd(`DCIF_OFF_FLAGS, 6);
    want <= 0;
    ticks(4);
    xfer(1, `DCIF_OFF_FLAGS, 7);
    rd(`DCIF_OFF_FLAGS, 0);
  endtask
  task t_term;
    xfer(1, `DCIF_OFF_CTRL, 0);
    cur_addr <= 0;
    xfer(1, `DCIF_OFF_CTRL, 1);
    want <= 1;
    ticks(5);
    want <= 0;
    stop <= 1;
    ticks(5);
    rd(`DCIF_OFF_STATE, 2);
    xfer(0, `DCIF_OFF_FLAGS, 0);
    chk(r & 32'h4, 0);
    stop <= 0;
  endtask
  task t_run_off;
    xfer(1, `DCIF_OFF_CTRL, 0);
    want <= 1;
    for (int i = 0; i < 6; i++) begin
      @(negedge clk);
      chk({31'h0, req_accept}, 0);
    end
    chk({31'h0, run}, 0);
    rd(`DCIF_OFF_STATE, 0);
    want <= 0;
    xfer(0, 8'h40, 0);
    chk({r[30:0], serr}, 1);
  endtask
  task t_reset_mid;
    xfer(1, `DCIF_OFF_ENABLES, 7);
    xfer(1, `DCIF_OFF_CTRL, 1);
    bus_err <= 1;
    @(posedge clk);
    bus_err <= 0;
    rd(`DCIF_OFF_FLAGS, 1);
    arst_n <= 0;
    ticks(2);
    arst_n <= 1;
    @(negedge clk);
    chk({29'h0, irq, run, req_accept}, 0);
    rd(`DCIF_OFF_FLAGS, 0);
    rd(`DCIF_OFF_ENABLES, 0);
    rd(`DCIF_OFF_CTRL, 0);
  endtask
  task t_freeze;
    ce <= 0;
    xfer(1, `DCIF_OFF_ENABLES, 7);
    bus_err <= 1;
    @(posedge clk);
    bus_err <= 0;
    ce <= 1;
    rd(`DCIF_OFF_ENABLES, 0);
    rd(`DCIF_OFF_FLAGS, 0);
  endtask
  task stop_test;
    $display("checks %0d mismatches %0d", cmp_count, failures);
    if (failures == 0 && cmp_count > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  // Hang guard
  initial begin
    #400000;
    failures++;
    stop_test;
  end
  // Main sequence
  initial begin
    arst_n = 0; psel = 0; penable = 0; pwrite = 0; paddr = 0; pwdata = 0;
    bus_err = 0; want = 0; stop = 0; cur_addr = 0; end_addr = 32'h00000100;
    ce = 1;
    failures = 0; cmp_count = 0;
    ticks(4);
    arst_n <= 1;
    t_reset;
    t_berr;
    t_done_ovf;
    t_term;
    t_run_off;
    t_reset_mid;
    t_freeze;
    stop_test;
  end
endmodule
